// ==== inc/reload_timer_pkg.sv ====
package reload_timer_pkg;

    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_PRESCALE = 8'h04;
    localparam logic [7:0] OFS_COUNT = 8'h08;
    localparam logic [7:0] OFS_SOURCE = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_MASK = 8'h14;
    localparam logic [7:0] OFS_PORT = 8'h18;

    localparam int MODE_LEVEL_BIT = 3;
    localparam int MODE_RUN_BIT = 4;
    localparam int MODE_INV_BIT = 5;
    localparam int PORT_DATA_BIT = 0;
    localparam int PORT_DIR_BIT = 1;
    localparam int PORT_IN_BIT = 2;
    localparam int STAT_UNDER_BIT = 0;
    localparam int HTRANS_ACTIVE_BIT = 1;

    localparam logic [7:0] COUNT_RESET = 8'hFF;
    localparam logic [7:0] PRESCALE_RESET = 8'hFF;
    localparam logic [2:0] DIV_STEP = 3'h1;
    localparam logic [2:0] DIV8_LAST = 3'h7;

    typedef enum logic [1:0] {
        SRC_DIV1 = 2'h0,
        SRC_DIV2 = 2'h1,
        SRC_DIV8 = 2'h2,
        SRC_RING = 2'h3
    } src_type;

    typedef enum logic [3:0] {
        PH_COUNT = 4'h1,
        PH_RELOAD = 4'h2,
        PH_XFER = 4'h4,
        PH_RESUME = 4'h8
    } phase_type;

    typedef struct packed {
        logic inverted_output_enable;
        logic count_run_flag;
        logic output_start_level_sel;
    } mode_type;

    typedef struct packed {
        logic dir;
        logic data;
    } port_type;

    localparam mode_type MODE_RESET = '{1'b0, 1'b0, 1'b0};
    localparam port_type PORT_RESET = '{1'b0, 1'b0};

endpackage

// ==== src/count_source_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
module count_source_gen (
    input wire logic hclk,
    input wire logic hresetn,
    input wire reload_timer_pkg::src_type sel,
    input wire logic ring_osc_clock,
    output logic tick
);

    logic [2:0] div_r;
    logic [2:0] div_nxt;
    logic ring_r;
    logic ring_nxt;
    logic tick_r;
    logic tick_nxt;

    always_comb
    begin
        div_nxt = div_r + reload_timer_pkg::DIV_STEP;
        ring_nxt = ring_osc_clock;
        case (sel)
            reload_timer_pkg::SRC_DIV1: tick_nxt = 1'b1;
            reload_timer_pkg::SRC_DIV2: tick_nxt = div_r[0];
            reload_timer_pkg::SRC_DIV8: tick_nxt = (div_r == reload_timer_pkg::DIV8_LAST);
            default: tick_nxt = ring_osc_clock & ~ring_r;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            div_r <= 3'h0;
            ring_r <= 1'b0;
            tick_r <= 1'b0;
        end
        else
        begin
            div_r <= div_nxt;
            ring_r <= ring_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;

    a_div8_spacing: assert property (@(posedge hclk) disable iff (!hresetn)
        (tick_r && sel == reload_timer_pkg::SRC_DIV8
            && $past(sel) == reload_timer_pkg::SRC_DIV8) |=>
        (!tick_r || sel != reload_timer_pkg::SRC_DIV8) [*7])
        else $error("divide-by-eight source ticked too soon");

endmodule // count_source_gen
`default_nettype wire

// ==== src/reload_timer_pulse_output.sv ====
`timescale 1ns/1ps
`default_nettype none
module reload_timer_pulse_output #(
    parameter int CNT_W = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic ring_osc_clock,
    input wire logic pulse_out_pin_i,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic shared_pulse_pin,
    output logic pulse_out_pin_o,
    output logic pulse_out_pin_oe,
    output logic irq
);

    reload_timer_pkg::mode_type timer_mode_reg_r, mode_nxt;
    reload_timer_pkg::src_type src_r, src_nxt;
    reload_timer_pkg::port_type port_r, port_nxt;
    reload_timer_pkg::phase_type phase_r, phase_nxt;
    logic [CNT_W-1:0] pre_cnt_r, pre_cnt_nxt, pre_rld_r, pre_rld_nxt;
    logic [CNT_W-1:0] main_cnt_r, main_cnt_nxt, main_rld_r, main_rld_nxt;
    logic [CNT_W-1:0] pre_pend_r, pre_pend_nxt, main_pend_r, main_pend_nxt;
    logic pre_flag_r, pre_flag_nxt, main_flag_r, main_flag_nxt;
    logic pulse_r, pulse_nxt, comp_o_r, comp_o_nxt, comp_oe_r, comp_oe_nxt;
    logic status_r, status_nxt, mask_r, mask_nxt, irq_r, irq_nxt;
    logic ap_valid_r, ap_valid_nxt, ap_write_r, ap_write_nxt;
    logic [7:0] ap_addr_r, ap_addr_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic hreadyout_r, hresp_r;
    logic tick;
    logic wr, wr_mode, wr_pre, wr_cnt, do_count, under_c;
    logic [CNT_W-1:0] wdata;

    count_source_gen u_src (
        .hclk(hclk),
        .hresetn(hresetn),
        .sel(src_r),
        .ring_osc_clock(ring_osc_clock),
        .tick(tick)
    );

    function automatic logic [31:0] read_word(input logic [7:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        if (a == reload_timer_pkg::OFS_MODE)
            d[reload_timer_pkg::MODE_INV_BIT:reload_timer_pkg::MODE_LEVEL_BIT] = timer_mode_reg_r;
        else if (a == reload_timer_pkg::OFS_PRESCALE)
            d[CNT_W-1:0] = pre_cnt_r;
        else if (a == reload_timer_pkg::OFS_COUNT)
            d[CNT_W-1:0] = main_cnt_r;
        else if (a == reload_timer_pkg::OFS_SOURCE)
            d[1:0] = src_r;
        else if (a == reload_timer_pkg::OFS_STATUS)
            d[reload_timer_pkg::STAT_UNDER_BIT] = status_r;
        else if (a == reload_timer_pkg::OFS_MASK)
            d[reload_timer_pkg::STAT_UNDER_BIT] = mask_r;
        else if (a == reload_timer_pkg::OFS_PORT)
        begin
            d[reload_timer_pkg::PORT_DIR_BIT:reload_timer_pkg::PORT_DATA_BIT] = port_r;
            d[reload_timer_pkg::PORT_IN_BIT] = pulse_out_pin_i;
        end
        return d;
    endfunction

    // Bus slave: address phase captured, write applied in the data phase
    always_comb
    begin
        ap_valid_nxt = hsel & htrans[reload_timer_pkg::HTRANS_ACTIVE_BIT] & hready;
        ap_write_nxt = hwrite;
        ap_addr_nxt = haddr[7:0];
        hrdata_nxt = hrdata_r;
        if (ap_valid_nxt && !hwrite)
            hrdata_nxt = read_word(haddr[7:0]);
        wr = ap_valid_r & ap_write_r;
        wr_mode = wr & (ap_addr_r == reload_timer_pkg::OFS_MODE);
        wr_pre = wr & (ap_addr_r == reload_timer_pkg::OFS_PRESCALE);
        wr_cnt = wr & (ap_addr_r == reload_timer_pkg::OFS_COUNT);
        wdata = hwdata[CNT_W-1:0];
    end

    // Timer core
    always_comb
    begin
        mode_nxt = timer_mode_reg_r;
        src_nxt = src_r;
        port_nxt = port_r;
        phase_nxt = phase_r;
        pre_cnt_nxt = pre_cnt_r;
        pre_rld_nxt = pre_rld_r;
        main_cnt_nxt = main_cnt_r;
        main_rld_nxt = main_rld_r;
        pre_pend_nxt = pre_pend_r;
        main_pend_nxt = main_pend_r;
        pre_flag_nxt = pre_flag_r;
        main_flag_nxt = main_flag_r;
        pulse_nxt = pulse_r;
        mask_nxt = mask_r;
        under_c = 1'b0;
        do_count = 1'b0;

        if (wr_mode)
            mode_nxt = reload_timer_pkg::mode_type'(
                hwdata[reload_timer_pkg::MODE_INV_BIT:reload_timer_pkg::MODE_LEVEL_BIT]);
        if (wr && ap_addr_r == reload_timer_pkg::OFS_SOURCE)
            src_nxt = reload_timer_pkg::src_type'(hwdata[1:0]);
        if (wr && ap_addr_r == reload_timer_pkg::OFS_MASK)
            mask_nxt = hwdata[reload_timer_pkg::STAT_UNDER_BIT];
        if (wr && ap_addr_r == reload_timer_pkg::OFS_PORT)
            port_nxt = reload_timer_pkg::port_type'(
                hwdata[reload_timer_pkg::PORT_DIR_BIT:reload_timer_pkg::PORT_DATA_BIT]);

        if (!timer_mode_reg_r.count_run_flag)
        begin
            // Halted mid-handoff: settle pending values at once
            if (pre_flag_r)
            begin
                pre_rld_nxt = pre_pend_r;
                pre_cnt_nxt = pre_pend_r;
            end
            if (main_flag_r)
            begin
                main_rld_nxt = main_pend_r;
                main_cnt_nxt = main_pend_r;
            end
            pre_flag_nxt = 1'b0;
            main_flag_nxt = 1'b0;
            phase_nxt = reload_timer_pkg::PH_COUNT;
        end
        else if (tick)
        begin
            case (phase_r)
                reload_timer_pkg::PH_RELOAD:
                begin
                    if (pre_flag_r)
                        pre_rld_nxt = pre_pend_r;
                    if (main_flag_r)
                        main_rld_nxt = main_pend_r;
                    phase_nxt = reload_timer_pkg::PH_XFER;
                end
                reload_timer_pkg::PH_XFER:
                begin
                    if (pre_flag_r)
                        pre_cnt_nxt = pre_rld_r;
                    if (main_flag_r)
                        main_cnt_nxt = main_rld_r;
                    pre_flag_nxt = 1'b0;
                    main_flag_nxt = 1'b0;
                    phase_nxt = reload_timer_pkg::PH_RESUME;
                end
                reload_timer_pkg::PH_RESUME:
                begin
                    do_count = 1'b1;
                    phase_nxt = reload_timer_pkg::PH_COUNT;
                end
                default:
                    do_count = 1'b1;
            endcase
        end

        if (do_count)
        begin
            if (pre_cnt_r == '0)
            begin
                pre_cnt_nxt = pre_rld_r;
                if (main_cnt_r == '0)
                begin
                    main_cnt_nxt = main_rld_r;
                    under_c = 1'b1;
                end
                else
                    main_cnt_nxt = main_cnt_r - 1'b1;
            end
            else
                pre_cnt_nxt = pre_cnt_r - 1'b1;
        end

        if (under_c)
            pulse_nxt = ~pulse_r;

        if (wr_pre)
        begin
            if (!timer_mode_reg_r.count_run_flag)
            begin
                pre_rld_nxt = wdata;
                pre_cnt_nxt = wdata;
            end
            else
            begin
                pre_pend_nxt = wdata;
                pre_flag_nxt = 1'b1;
                phase_nxt = reload_timer_pkg::PH_RELOAD;
            end
        end
        if (wr_cnt)
        begin
            pulse_nxt = timer_mode_reg_r.output_start_level_sel;
            if (!timer_mode_reg_r.count_run_flag)
            begin
                main_rld_nxt = wdata;
                main_cnt_nxt = wdata;
            end
            else
            begin
                main_pend_nxt = wdata;
                main_flag_nxt = 1'b1;
                phase_nxt = reload_timer_pkg::PH_RELOAD;
            end
        end

        // Clearing by write-one loses to a same-cycle underflow
        status_nxt = (status_r & ~(wr && ap_addr_r == reload_timer_pkg::OFS_STATUS
            && hwdata[reload_timer_pkg::STAT_UNDER_BIT])) | under_c;
        irq_nxt = status_nxt & mask_nxt;
        comp_o_nxt = mode_nxt.inverted_output_enable ? ~pulse_nxt : port_nxt.data;
        comp_oe_nxt = mode_nxt.inverted_output_enable | port_nxt.dir;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_valid_r <= 1'b0;
            ap_write_r <= 1'b0;
            ap_addr_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
            timer_mode_reg_r <= reload_timer_pkg::MODE_RESET;
            src_r <= reload_timer_pkg::SRC_DIV1;
            port_r <= reload_timer_pkg::PORT_RESET;
            phase_r <= reload_timer_pkg::PH_COUNT;
            pre_cnt_r <= reload_timer_pkg::PRESCALE_RESET;
            pre_rld_r <= reload_timer_pkg::PRESCALE_RESET;
            main_cnt_r <= reload_timer_pkg::COUNT_RESET;
            main_rld_r <= reload_timer_pkg::COUNT_RESET;
            pre_pend_r <= '0;
            main_pend_r <= '0;
            pre_flag_r <= 1'b0;
            main_flag_r <= 1'b0;
            pulse_r <= 1'b0;
            comp_o_r <= 1'b0;
            comp_oe_r <= 1'b0;
            status_r <= 1'b0;
            mask_r <= 1'b0;
            irq_r <= 1'b0;
        end
        else
        begin
            ap_valid_r <= ap_valid_nxt;
            ap_write_r <= ap_write_nxt;
            ap_addr_r <= ap_addr_nxt;
            hrdata_r <= hrdata_nxt;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
            timer_mode_reg_r <= mode_nxt;
            src_r <= src_nxt;
            port_r <= port_nxt;
            phase_r <= phase_nxt;
            pre_cnt_r <= pre_cnt_nxt;
            pre_rld_r <= pre_rld_nxt;
            main_cnt_r <= main_cnt_nxt;
            main_rld_r <= main_rld_nxt;
            pre_pend_r <= pre_pend_nxt;
            main_pend_r <= main_pend_nxt;
            pre_flag_r <= pre_flag_nxt;
            main_flag_r <= main_flag_nxt;
            pulse_r <= pulse_nxt;
            comp_o_r <= comp_o_nxt;
            comp_oe_r <= comp_oe_nxt;
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = hresp_r;
    assign shared_pulse_pin = pulse_r;
    assign pulse_out_pin_o = comp_o_r;
    assign pulse_out_pin_oe = comp_oe_r;
    assign irq = irq_r;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_write_running;
        wr_cnt && timer_mode_reg_r.count_run_flag;
    endsequence

    sequence s_first_tick;
        tick && timer_mode_reg_r.count_run_flag && !wr_pre && !wr_cnt
            && phase_r == reload_timer_pkg::PH_RELOAD;
    endsequence

    a_underflow_irq: assert property (under_c |=> status_r)
        else $error("underflow did not set status");
    a_pulse_toggle: assert property (under_c && !wr_cnt |=> shared_pulse_pin != $past(pulse_r))
        else $error("pulse pin did not toggle on underflow");
    a_inverse_pin: assert property (timer_mode_reg_r.inverted_output_enable
        |-> pulse_out_pin_o == !shared_pulse_pin && pulse_out_pin_oe)
        else $error("second pin is not the inverse of the pulse");
    a_halt_holds: assert property (!timer_mode_reg_r.count_run_flag && !wr_cnt && !wr_pre
        && !pre_flag_r && !main_flag_r
        |=> $stable(main_cnt_r) && $stable(pre_cnt_r) && $stable(shared_pulse_pin))
        else $error("halted timer changed state");
    a_halted_write: assert property (wr_cnt && !timer_mode_reg_r.count_run_flag
        |=> main_cnt_r == $past(wdata) && main_rld_r == $past(wdata))
        else $error("halted write did not load both");
    a_staged_hold: assert property (s_write_running |=> main_flag_r
        && phase_r == reload_timer_pkg::PH_RELOAD && ($stable(main_cnt_r) || $past(do_count)))
        else $error("running write did not enter the handoff");
    a_staged_reload: assert property (s_first_tick
        |=> phase_r == reload_timer_pkg::PH_XFER)
        else $error("handoff steps out of order");
    a_staged_xfer: assert property (tick && timer_mode_reg_r.count_run_flag
        && !wr_pre && !wr_cnt && phase_r == reload_timer_pkg::PH_XFER
        |=> phase_r == reload_timer_pkg::PH_RESUME && !main_flag_r && !pre_flag_r)
        else $error("handoff did not copy and resume");
    a_start_level: assert property (wr_cnt |=> shared_pulse_pin
        == $past(timer_mode_reg_r.output_start_level_sel))
        else $error("count write did not restore start level");
    a_underflow_reload: assert property (under_c && !wr_cnt && !wr_pre
        |=> main_cnt_r == $past(main_rld_r) && pre_cnt_r == $past(pre_rld_r))
        else $error("underflow did not reload");
    a_cascade_step: assert property (do_count && pre_cnt_r == '0 && main_cnt_r != '0
        && !wr_cnt |=> main_cnt_r == $past(main_cnt_r) - 1'b1)
        else $error("main counter did not step on prescaler underflow");

endmodule // reload_timer_pulse_output
`default_nettype wire

// ==== dv/reload_timer_pulse_output_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module reload_timer_pulse_output_tb;
    typedef struct packed {
        logic [31:0] val;
        logic ne;
    } note_type;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic ring_osc_clock = 1'b0;
    logic [1:0] ring_cnt = 2'h0;
    logic ext_lvl = 1'b0;
    logic rd_dphase = 1'b0;
    logic hready;
    logic pulse_out_pin_i;
    logic [31:0] hrdata;
    logic hreadyout, hresp, shared_pulse_pin, pulse_out_pin_o, pulse_out_pin_oe, irq;
    int num_errors = 0;
    int tests_run = 0;
    note_type exp_q[$];
    note_type cur;

    // Single slave, so its ready is the bus ready; the second pin resolves drive against the world
    assign hready = hreadyout;
    assign pulse_out_pin_i = pulse_out_pin_oe ? pulse_out_pin_o : ext_lvl;

    reload_timer_pulse_output DUT (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .ring_osc_clock(ring_osc_clock),
        .pulse_out_pin_i(pulse_out_pin_i),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .shared_pulse_pin(shared_pulse_pin),
        .pulse_out_pin_o(pulse_out_pin_o),
        .pulse_out_pin_oe(pulse_out_pin_oe),
        .irq(irq)
    );

    initial
    begin
        forever #2.5 hclk = ~hclk;
    end

    // Ring oscillator stand-in: one rising edge every six bus cycles
    always @(posedge hclk)
    begin
        ring_cnt <= (ring_cnt == 2'h2) ? 2'h0 : ring_cnt + 2'h1;
        if (ring_cnt == 2'h2)
            ring_osc_clock <= ~ring_osc_clock;
    end

    // Read data is taken at the edge that ends the data phase
    always @(posedge hclk)
    begin
        if (rd_dphase && hready)
        begin
            cur = exp_q.pop_front();
            tests_run++;
            if ((hrdata === cur.val) === cur.ne)
            begin
                num_errors++;
                $display("unexpected read at %0t: got %h expected %h", $time, hrdata, cur.val);
            end
            if (hresp !== 1'b0)
            begin
                num_errors++;
                $display("unexpected hresp at %0t: got %h expected %h", $time, hresp, 1'b0);
            end
        end
    end

    task automatic complete_run();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_rdy();
        int i;
        i = 0;
        @(posedge hclk);
        while (hready !== 1'b1 && i < 200)
        begin
            @(posedge hclk);
            i++;
        end
        if (i >= 200)
        begin
            num_errors++;
            $display("unexpected hang at %0t: got %h expected %h", $time, 1'b0, 1'b1);
            complete_run();
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic ne);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        hsize <= 3'h2;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? d : $urandom;
        if (!wr)
        begin
            exp_q.push_back('{d, ne});
            rd_dphase <= 1'b1;
        end
        wait_rdy();
        rd_dphase <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 1'b0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d);
        bus(1'b0, a, d, 1'b0);
    endtask

    function automatic logic [31:0] mv(input logic run, input logic lvl, input logic inv);
        mv = 32'h0;
        mv[reload_timer_pkg::MODE_RUN_BIT] = run;
        mv[reload_timer_pkg::MODE_LEVEL_BIT] = lvl;
        mv[reload_timer_pkg::MODE_INV_BIT] = inv;
    endfunction

    // First pass syncs to a toggle, second counts one full interval
    task automatic period(output int c);
        logic l;
        for (int k = 0; k < 2; k++)
        begin
            l = shared_pulse_pin;
            c = 0;
            while (shared_pulse_pin === l && c < 3000)
            begin
                @(posedge hclk);
                #1;
                c++;
            end
        end
    endtask

    initial
    begin
        int seed, n, m, c;
        int div[4] = '{1, 2, 8, 6};
        logic l;
        seed = $urandom(32'h0817AE0B);
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(reload_timer_pkg::OFS_MODE, 32'h0);
        rd(reload_timer_pkg::OFS_PRESCALE, 32'hFF);
        rd(reload_timer_pkg::OFS_COUNT, 32'hFF);
        rd(reload_timer_pkg::OFS_SOURCE, 32'h0);
        rd(reload_timer_pkg::OFS_STATUS, 32'h0);
        rd(reload_timer_pkg::OFS_MASK, 32'h0);
        rd(reload_timer_pkg::OFS_PORT, 32'h0);
        wr(8'h1C, 32'hFFFFFFFF);
        rd(8'h1C, 32'h0);
        check(shared_pulse_pin, 32'h0);
        for (int s = 0; s < 4; s++)
        begin
            n = $urandom_range(3);
            m = $urandom_range(3);
            wr(reload_timer_pkg::OFS_SOURCE, 32'(s));
            wr(reload_timer_pkg::OFS_PRESCALE, 32'(n));
            wr(reload_timer_pkg::OFS_COUNT, 32'(m));
            rd(reload_timer_pkg::OFS_PRESCALE, 32'(n));
            rd(reload_timer_pkg::OFS_COUNT, 32'(m));
            wr(reload_timer_pkg::OFS_MODE, mv(1'b1, 1'b0, 1'b0));
            period(c);
            check(32'(c), 32'((n + 1) * (m + 1) * div[s]));
            wr(reload_timer_pkg::OFS_MODE, 32'h0);
        end
        wr(reload_timer_pkg::OFS_SOURCE, 32'h2);
        wr(reload_timer_pkg::OFS_PRESCALE, 32'h0);
        wr(reload_timer_pkg::OFS_COUNT, 32'h3);
        wr(reload_timer_pkg::OFS_MODE, mv(1'b1, 1'b1, 1'b0));
        period(c);
        check(32'(c), 32'd32);
        wr(reload_timer_pkg::OFS_COUNT, 32'h1);
        #1;
        check(shared_pulse_pin, 32'h1);
        period(c);
        check(32'(c), 32'd16);
        wr(reload_timer_pkg::OFS_MODE, 32'h0);
        wr(reload_timer_pkg::OFS_SOURCE, 32'h0);
        wr(reload_timer_pkg::OFS_COUNT, 32'hFF);
        #1;
        check(shared_pulse_pin, 32'h0);
        wr(reload_timer_pkg::OFS_MODE, mv(1'b1, 1'b0, 1'b0));
        repeat (20) @(posedge hclk);
        wr(reload_timer_pkg::OFS_MODE, 32'h0);
        bus(1'b0, reload_timer_pkg::OFS_COUNT, 32'hFF, 1'b1);
        wr(reload_timer_pkg::OFS_COUNT, 32'h5);
        repeat (40) @(posedge hclk);
        rd(reload_timer_pkg::OFS_COUNT, 32'h5);
        wr(reload_timer_pkg::OFS_COUNT, 32'h0);
        wr(reload_timer_pkg::OFS_MODE, mv(1'b1, 1'b0, 1'b1));
        repeat (4) @(posedge hclk);
        #1;
        check(pulse_out_pin_o, !shared_pulse_pin);
        check(pulse_out_pin_oe, 32'h1);
        check(irq, 32'h0);
        wr(reload_timer_pkg::OFS_MODE, mv(1'b0, 1'b0, 1'b1));
        repeat (2) @(posedge hclk);
        #1;
        l = shared_pulse_pin;
        repeat (30)
        begin
            @(posedge hclk);
            #1;
            check(shared_pulse_pin, l);
            check(pulse_out_pin_o, !l);
        end
        rd(reload_timer_pkg::OFS_STATUS, 32'h1);
        wr(reload_timer_pkg::OFS_MASK, 32'h1);
        #1;
        check(irq, 32'h1);
        wr(reload_timer_pkg::OFS_STATUS, 32'h1);
        #1;
        check(irq, 32'h0);
        rd(reload_timer_pkg::OFS_STATUS, 32'h0);
        wr(reload_timer_pkg::OFS_MODE, 32'h0);
        ext_lvl <= 1'b1;
        wr(reload_timer_pkg::OFS_PORT, 32'h3);
        #1;
        check(pulse_out_pin_o, 32'h1);
        check(pulse_out_pin_oe, 32'h1);
        wr(reload_timer_pkg::OFS_PORT, 32'h0);
        #1;
        check(pulse_out_pin_oe, 32'h0);
        rd(reload_timer_pkg::OFS_PORT, 32'h4);
        repeat (2) @(posedge hclk);
        complete_run();
    end
endmodule // reload_timer_pulse_output_tb
`default_nettype wire
